// file: include/adct_pkg.sv
package adct_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFS_CHANNEL_CONTROL = 12'h000;
  localparam logic [11:0] OFS_FORMAT_CLOCK_REF = 12'h004;
  localparam logic [11:0] OFS_TRIGGER_SELECT = 12'h008;
  localparam logic [11:0] OFS_RESULT_UPPER = 12'h00C;
  localparam logic [11:0] OFS_RESULT_LOWER = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_PWM_MASK = 12'h018;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int POS_ENABLE = 0;
  localparam int POS_GO = 1;
  localparam int POS_INSEL = 2;
  localparam int POS_PREF = 0;
  localparam int POS_CLKSEL = 4;
  localparam int POS_JUSTIFY = 7;
  localparam int POS_TRIGSEL = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ************************************************************
  // codes
  // ************************************************************
  localparam logic [3:0] TRIG_NONE = 4'h0;
  localparam logic [3:0] TRIG_PWM1_IRQ = 4'h1;
  localparam logic [3:0] TRIG_PWM2_IRQ = 4'h2;
  localparam logic [3:0] TRIG_TIMER_A = 4'h3;
  localparam logic [3:0] TRIG_TIMER_B = 4'h4;
  localparam logic [3:0] TRIG_TIMER_C = 4'h5;
  localparam logic [3:0] TRIG_COMP = 4'h6;
  localparam logic [3:0] TRIG_PWM3_IRQ = 4'h7;
  localparam logic [3:0] TRIG_PWM1_OFS = 4'h8;
  localparam logic [3:0] TRIG_PWM2_OFS = 4'h9;
  localparam logic [3:0] TRIG_PWM3_OFS = 4'hA;
  localparam logic [4:0] INSEL_EXT_LAST = 5'h03;
  localparam logic [4:0] INSEL_TEMP = 5'h1D;
  localparam logic [4:0] INSEL_DAC = 5'h1E;
  localparam logic [4:0] INSEL_FIXREF = 5'h1F;
  localparam int BIT_PERIODS = 11;
  localparam int SAMPLE_CONV_PERIODS_X2 = 23;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } adct_state_t;

  // analog front-end controls
  typedef struct packed {
    logic powerOn;
    logic sampleHold;
    logic [6:0] channelOneHot;
    logic [2:0] refOneHot;
    logic rcClockOn;
    logic [9:0] trialCode;
  } adct_analog_t;

  // trigger sources coming from other peripherals
  typedef struct packed {
    logic [2:0][3:0] pwmMatch;
    logic [2:0] pwmOffsetMatch;
    logic timerAOverflow;
    logic timerBOverflow;
    logic timerCPeriodMatch;
    logic comparatorSyncOut;
  } adct_trig_t;
endpackage

// file: design/adct_control.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
module adct_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adct_pkg::adct_trig_t trig,
  input wire logic rcTick,
  input wire logic compareHigh,
  output adct_pkg::adct_analog_t analog,
  output logic timerAFlagSet,
  output logic timerBFlagSet
);
  import adct_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic enable;
  logic go;
  logic [4:0] inputSelect;
  logic justify;
  logic [2:0] clockSelect;
  logic [1:0] refSelect;
  logic [3:0] trigSelect;
  logic [11:0] pwmMask;
  logic doneFlag;
  logic [7:0] resultHigh;
  logic [7:0] resultLow;
  adct_state_t state;
  logic [9:0] sar;
  logic [3:0] bitIdx;
  logic [4:0] halfCount;
  logic [5:0] divCount;
  logic [1:0] rcSync;
  logic rcPrev;
  logic trigPrev;

  wire logic wrAcc = psel && penable && pwrite;
  wire logic mapped = paddr <= OFS_PWM_MASK && paddr[1:0] == 2'b00;

  // ************************************************************
  // conversion clock: half-period enable
  // ************************************************************
  logic [5:0] halfDiv;
  logic halfTick;
  always_comb begin
    unique case (clockSelect)
      3'b000: halfDiv = 6'd0;
      3'b100: halfDiv = 6'd1;
      3'b001: halfDiv = 6'd3;
      3'b101: halfDiv = 6'd7;
      3'b010: halfDiv = 6'd15;
      3'b110: halfDiv = 6'd31;
      default: halfDiv = 6'd0;
    endcase
  end

  // rc tick is asynchronous; first stage read only by second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcSync <= 2'b00;
      rcPrev <= 1'b0;
    end else begin
      rcSync <= {rcSync[0], rcTick};
      rcPrev <= rcSync[1];
    end
  end

  wire logic rcMode = clockSelect[1:0] == 2'b11;
  assign halfTick = rcMode ? (rcSync[1] != rcPrev) : (divCount == halfDiv);

  always_ff @(posedge clk) begin
    if (!rst_n || state == ST_IDLE || halfTick) begin
      divCount <= 6'd0;
    end else begin
      divCount <= divCount + 6'd1;
    end
  end

  // ************************************************************
  // trigger selection and edge detect
  // ************************************************************
  logic trigLevel;
  always_comb begin
    unique case (trigSelect)
      TRIG_PWM1_IRQ: trigLevel = |(trig.pwmMatch[0] & pwmMask[3:0]);
      TRIG_PWM2_IRQ: trigLevel = |(trig.pwmMatch[1] & pwmMask[7:4]);
      TRIG_PWM3_IRQ: trigLevel = |(trig.pwmMatch[2] & pwmMask[11:8]);
      TRIG_TIMER_A: trigLevel = trig.timerAOverflow;
      TRIG_TIMER_B: trigLevel = trig.timerBOverflow;
      TRIG_TIMER_C: trigLevel = trig.timerCPeriodMatch;
      TRIG_COMP: trigLevel = trig.comparatorSyncOut;
      TRIG_PWM1_OFS: trigLevel = trig.pwmOffsetMatch[0];
      TRIG_PWM2_OFS: trigLevel = trig.pwmOffsetMatch[1];
      TRIG_PWM3_OFS: trigLevel = trig.pwmOffsetMatch[2];
      default: trigLevel = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= trigLevel;
    end
  end
  // no acquisition wait inserted; software must allow for it
  wire logic trigStart = trigLevel && !trigPrev && enable;

  // timer flags set regardless of conversion use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timerAFlagSet <= 1'b0;
      timerBFlagSet <= 1'b0;
    end else begin
      timerAFlagSet <= trig.timerAOverflow;
      timerBFlagSet <= trig.timerBOverflow;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  wire logic wrGo = wrAcc && paddr == OFS_CHANNEL_CONTROL;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {inputSelect, enable} <= 6'h00;
      {justify, clockSelect, refSelect} <= 6'h00;
      trigSelect <= 4'h0;
      pwmMask <= 12'h000;
    end else if (wrAcc) begin
      unique case (paddr)
        OFS_CHANNEL_CONTROL: begin
          inputSelect <= pwdata[POS_INSEL +: 5];
          enable <= pwdata[POS_ENABLE];
        end
        OFS_FORMAT_CLOCK_REF: begin
          justify <= pwdata[POS_JUSTIFY];
          clockSelect <= pwdata[POS_CLKSEL +: 3];
          refSelect <= pwdata[POS_PREF +: 2];
        end
        OFS_TRIGGER_SELECT: trigSelect <= pwdata[POS_TRIGSEL +: 4];
        OFS_PWM_MASK: pwmMask <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // conversion engine
  // ************************************************************
  wire logic finish = state == ST_CONV && halfTick && halfCount == 5'(SAMPLE_CONV_PERIODS_X2 - 1);
  wire logic abort = state == ST_CONV && wrGo && !pwdata[POS_GO];
  wire logic swStart = wrGo && pwdata[POS_GO] && pwdata[POS_ENABLE] && enable;

  // fill unconverted bits with the last decided bit
  logic [9:0] partial;
  always_comb begin
    partial = sar;
    for (int i = 0; i < 10; i++) begin
      if (i < 10 - int'(bitIdx)) begin
        partial[i] = (bitIdx == 4'd0) ? 1'b0 : sar[10 - int'(bitIdx)];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      go <= 1'b0;
      sar <= 10'h000;
      bitIdx <= 4'd0;
      halfCount <= 5'd0;
    end else if (state == ST_IDLE) begin
      if (swStart || trigStart) begin
        state <= ST_CONV;
        go <= 1'b1;
        sar <= 10'h200;
        bitIdx <= 4'd0;
        halfCount <= 5'd0;
      end
    end else if (abort || finish || !enable) begin
      state <= ST_IDLE;
      go <= 1'b0;
    end else if (halfTick) begin
      halfCount <= halfCount + 5'd1;
      // one bit per full period; comparator settles within a clock of trialCode
      if (halfCount[0] && bitIdx < 4'(BIT_PERIODS - 1)) begin
        sar[9 - bitIdx] <= compareHigh ? 1'b1 : 1'b0;
        if (bitIdx < 4'd9) begin
          sar[8 - bitIdx] <= 1'b1;
        end
        bitIdx <= bitIdx + 4'd1;
      end
    end
  end

  // ************************************************************
  // results and done flag
  // ************************************************************
  wire logic [9:0] stored = finish ? sar : partial;
  always_ff @(posedge clk) begin
    // results survive reset: no reset branch
    if (finish || abort) begin
      if (justify) begin
        resultHigh <= {6'h00, stored[9:8]};
        resultLow <= stored[7:0];
      end else begin
        resultHigh <= stored[9:2];
        resultLow <= {stored[1:0], 6'h00};
      end
    end else if (wrAcc && paddr == OFS_RESULT_UPPER) begin
      resultHigh <= pwdata[7:0];
    end else if (wrAcc && paddr == OFS_RESULT_LOWER) begin
      resultLow <= pwdata[7:0];
    end
  end

  // done flag: write one to clear, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doneFlag <= 1'b0;
    end else if (finish) begin
      doneFlag <= 1'b1;
    end else if (wrAcc && paddr == OFS_STATUS && pwdata[0]) begin
      doneFlag <= 1'b0;
    end
  end

  // ************************************************************
  // analog outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog <= '0;
    end else begin
      analog.powerOn <= enable;
      analog.sampleHold <= state == ST_CONV && halfCount == 5'd0;
      analog.rcClockOn <= enable && rcMode;
      analog.trialCode <= sar;
      analog.channelOneHot <= 7'h00;
      if (inputSelect <= INSEL_EXT_LAST) begin
        analog.channelOneHot <= 7'(1) << inputSelect[1:0];
      end else if (inputSelect == INSEL_TEMP) begin
        analog.channelOneHot <= 7'h10;
      end else if (inputSelect == INSEL_DAC) begin
        analog.channelOneHot <= 7'h20;
      end else if (inputSelect == INSEL_FIXREF) begin
        analog.channelOneHot <= 7'h40;
      end
      unique case (refSelect)
        2'b00: analog.refOneHot <= 3'b001;
        2'b10: analog.refOneHot <= 3'b010;
        2'b11: analog.refOneHot <= 3'b100;
        default: analog.refOneHot <= 3'b000;
      endcase
    end
  end

  // ************************************************************
  // apb read side
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFS_CHANNEL_CONTROL: prdata[7:0] <= {1'b0, inputSelect, go, enable};
          OFS_FORMAT_CLOCK_REF: prdata[7:0] <= {justify, clockSelect, 2'b00, refSelect};
          OFS_TRIGGER_SELECT: prdata[7:0] <= {trigSelect, 4'h0};
          OFS_RESULT_UPPER: prdata[7:0] <= resultHigh;
          OFS_RESULT_LOWER: prdata[7:0] <= resultLow;
          OFS_STATUS: prdata[0] <= doneFlag;
          OFS_PWM_MASK: prdata[11:0] <= pwmMask;
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_done_with_go: assert property (@(posedge clk) disable iff (!rst_n)
    finish |=> !go && doneFlag) else $error("done not set with go clear");
  chk_trig_starts: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_IDLE && trigStart |=> go) else $error("trigger edge did not start");
  chk_reserved_trig: assert property (@(posedge clk) disable iff (!rst_n)
    trigSelect > TRIG_PWM3_OFS |-> !trigLevel) else $error("reserved trigger active");
  chk_right_zero: assert property (@(posedge clk) disable iff (!rst_n)
    finish && justify |=> resultHigh[7:2] == 6'h00) else $error("upper bits not zero");
  chk_left_zero: assert property (@(posedge clk) disable iff (!rst_n)
    finish && !justify |=> resultLow[5:0] == 6'h00) else $error("lower bits not zero");
  chk_go_readback: assert property (@(posedge clk) disable iff (!rst_n)
    swStart && state == ST_IDLE |=> go [*2]) else $error("go not held");
  chk_power_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !analog.powerOn) else $error("powered while disabled");
  chk_abort_stops: assert property (@(posedge clk) disable iff (!rst_n)
    abort |=> state == ST_IDLE && !go) else $error("abort ignored");
  chk_timer_flag: assert property (@(posedge clk) disable iff (!rst_n)
    trig.timerAOverflow |=> timerAFlagSet) else $error("timer flag lost");
  chk_length: assert property (@(posedge clk) disable iff (!rst_n)
    finish && clockSelect == 3'h0 |-> $past(state, 23) == ST_IDLE && $past(state, 22) == ST_CONV)
    else $error("wrong conversion length");
endmodule // adct_control

// file: testbench/adct_partner.sv
`timescale 1ns/1ns
// ************************************************************
// comparator and rc oscillator of the analog side
// ************************************************************
module adct_partner
  import adct_pkg::*;
(
  input wire adct_pkg::adct_analog_t analog,
  input wire logic [9:0] target,
  output logic compareHigh,
  output logic rcTick
);
  // keep a trial bit while the held input is at or above it
  assign compareHigh = analog.trialCode <= target;
  // rc clock runs only while requested, phase unrelated to clk
  initial begin
    rcTick = 1'b0;
    forever begin
      #70;
      if (analog.rcClockOn) begin
        rcTick = ~rcTick;
      end
    end
  end
endmodule // adct_partner

// file: testbench/adct_control_tb.sv
`timescale 1ns/1ns
module adct_control_tb;
  import adct_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  adct_trig_t trig;
  adct_analog_t analog;
  logic rcTick, compareHigh, timerAFlagSet, timerBFlagSet;
  logic [9:0] target;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int dur;
  int lim;
  int divs[6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0] clkCodes[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  logic [4:0] chCodes[7] = '{5'h00, 5'h03, 5'h04, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  logic [6:0] chHot[7] = '{7'h01, 7'h08, 7'h00, 7'h00, 7'h10, 7'h20, 7'h40};
  logic [2:0] refHot[4] = '{3'h1, 3'h0, 3'h2, 3'h4};
  logic [3:0] offCodes[6] = '{4'h0, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  adct_control uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig(trig), .rcTick(rcTick), .compareHigh(compareHigh), .analog(analog),
    .timerAFlagSet(timerAFlagSet), .timerBFlagSet(timerBFlagSet));
  adct_partner partner (.analog(analog), .target(target), .compareHigh(compareHigh),
    .rcTick(rcTick));

  // ************************************************************
  // access tasks
  // ************************************************************
  task conclude;
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // poll go until the converter is idle again
  task waitIdle(output int d);
    int s;
    int n;
    s = cyc;
    n = 0;
    do begin
      apb(1'b0, OFS_CHANNEL_CONTROL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 400);
    if (rd[1] !== 1'b0) begin
      errors++;
      conclude();
    end
    d = cyc - s;
  endtask
  task convCheck(input logic j);
    lim = j ? {30'h0, target[9:8]} : {24'h0, target[9:2]};
    rdchk("resultUpper", OFS_RESULT_UPPER, lim);
    lim = j ? {24'h0, target[7:0]} : {24'h0, target[1:0], 6'h0};
    rdchk("resultLower", OFS_RESULT_LOWER, lim);
    rdchk("doneFlag", OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rdchk("doneClear", OFS_STATUS, 32'h0);
  endtask
  task setSrc(input logic [3:0] c, input logic v);
    case (c)
      4'h1: trig.pwmMatch[0][1] <= v;
      4'h2: trig.pwmMatch[1][3] <= v;
      4'h3: trig.timerAOverflow <= v;
      4'h4: trig.timerBOverflow <= v;
      4'h5: trig.timerCPeriodMatch <= v;
      4'h6: trig.comparatorSyncOut <= v;
      4'h7: trig.pwmMatch[2][0] <= v;
      4'h8: trig.pwmOffsetMatch[0] <= v;
      4'h9: trig.pwmOffsetMatch[1] <= v;
      4'hA: trig.pwmOffsetMatch[2] <= v;
      default: trig <= {$bits(adct_trig_t){v}};
    endcase
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig = '0;
    target = 10'h2A5;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrlReset", OFS_CHANNEL_CONTROL, 32'h0);
    rdchk("fmtReset", OFS_FORMAT_CLOCK_REF, 32'h0);
    rdchk("trigReset", OFS_TRIGGER_SELECT, 32'h0);
    chk("powerOff", 32'h0, analog.powerOn);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmappedErr", 32'h1, err);
    chk("unmappedData", 32'h0, rd);
    wr(OFS_FORMAT_CLOCK_REF, 32'hFF);
    rdchk("fmtBits", OFS_FORMAT_CLOCK_REF, 32'hF3);
    wr(OFS_TRIGGER_SELECT, 32'hFF);
    rdchk("trigBits", OFS_TRIGGER_SELECT, 32'hF0);
    wr(OFS_TRIGGER_SELECT, 32'h0);
    wr(OFS_CHANNEL_CONTROL, 32'hFD);
    rdchk("ctrlBits", OFS_CHANNEL_CONTROL, 32'h7D);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CHANNEL_CONTROL, {25'h0, chCodes[i], 2'b01});
      repeat (2) @(posedge clk);
      chk("channelOneHot", {25'h0, chHot[i]}, analog.channelOneHot);
    end
    chk("powerOn", 32'h1, analog.powerOn);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FORMAT_CLOCK_REF, i);
      repeat (2) @(posedge clk);
      chk("refOneHot", {29'h0, refHot[i]}, analog.refOneHot);
    end
    // configure and enable first, start only afterwards
    wr(OFS_CHANNEL_CONTROL, 32'h01);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_FORMAT_CLOCK_REF, {24'h0, 1'b1, clkCodes[i], 4'h0});
      wr(OFS_CHANNEL_CONTROL, 32'h03);
      rdchk("goBusy", OFS_CHANNEL_CONTROL, 32'h03);
      waitIdle(dur);
      // start edge three cycles before polling; polls three cycles apart
      lim = divs[i] * 23 / 2;
      chk("convTime", 32'h1, dur >= lim - 2 && dur <= lim + 2);
      convCheck(1'b1);
    end
    wr(OFS_FORMAT_CLOCK_REF, 32'hB0);
    wr(OFS_CHANNEL_CONTROL, 32'h03);
    waitIdle(dur);
    convCheck(1'b1);
    // abort before any bit is decided leaves a zero result
    wr(OFS_FORMAT_CLOCK_REF, 32'hE0);
    wr(OFS_CHANNEL_CONTROL, 32'h03);
    wr(OFS_CHANNEL_CONTROL, 32'h01);
    rdchk("abortGo", OFS_CHANNEL_CONTROL, 32'h01);
    rdchk("abortUpper", OFS_RESULT_UPPER, 32'h0);
    rdchk("abortLower", OFS_RESULT_LOWER, 32'h0);
    // abort after only the top bit is decided: the rest copy it
    wr(OFS_FORMAT_CLOCK_REF, 32'h80);
    wr(OFS_CHANNEL_CONTROL, 32'h03);
    wr(OFS_CHANNEL_CONTROL, 32'h01);
    rdchk("partUpper", OFS_RESULT_UPPER, 32'h3);
    rdchk("partLower", OFS_RESULT_LOWER, 32'hFF);
    wr(OFS_STATUS, 32'h1);
    target <= 10'h15A;
    wr(OFS_FORMAT_CLOCK_REF, 32'h00);
    wr(OFS_CHANNEL_CONTROL, 32'h03);
    waitIdle(dur);
    convCheck(1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrlReset2", OFS_CHANNEL_CONTROL, 32'h0);
    rdchk("keptUpper", OFS_RESULT_UPPER, {24'h0, target[9:2]});
    // hardware triggers, the first only one register write after enable; no acquisition wait
    wr(OFS_PWM_MASK, 32'hFFF);
    wr(OFS_FORMAT_CLOCK_REF, 32'h80);
    wr(OFS_CHANNEL_CONTROL, 32'h01);
    for (int c = 1; c <= 10; c++) begin
      wr(OFS_TRIGGER_SELECT, c << 4);
      setSrc(4'(c), 1'b1);
      repeat (3) @(posedge clk);
      if (c == 3) chk("timerAFlag", 32'h1, timerAFlagSet);
      if (c == 4) chk("timerBFlag", 32'h1, timerBFlagSet);
      waitIdle(dur);
      convCheck(1'b1);
      repeat (40) @(posedge clk);
      rdchk("levelNoStart", OFS_STATUS, 32'h0);
      setSrc(4'(c), 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      wr(OFS_TRIGGER_SELECT, {24'h0, offCodes[i], 4'h0});
      setSrc(offCodes[i], 1'b1);
      repeat (40) @(posedge clk);
      rdchk("reservedNoStart", OFS_STATUS, 32'h0);
      setSrc(offCodes[i], 1'b0);
    end
    wr(OFS_PWM_MASK, 32'hFFD);
    wr(OFS_TRIGGER_SELECT, 32'h10);
    setSrc(4'h1, 1'b1);
    repeat (40) @(posedge clk);
    rdchk("maskedNoStart", OFS_STATUS, 32'h0);
    conclude();
  end
endmodule // adct_control_tb
